// >>> include/adc_ctrl_pkg.sv
// Package for the converter control block: register map, fields, timing.
// Assumes an 8-bit special-register port from the core, one 200 MHz clock.
package adc_ctrl_pkg;

  localparam logic [3:0] OFF_PIN_EN   = 4'h5;
  localparam logic [3:0] OFF_CTRL     = 4'h6;
  localparam logic [3:0] OFF_RES_HI   = 4'h8;
  localparam logic [3:0] OFF_RES_LO   = 4'h9;

  localparam int         BIT_REF_SEL  = 7;
  localparam int         BIT_DIV_HI   = 6;
  localparam int         BIT_DIV_LO   = 5;
  localparam int         BIT_GO       = 4;
  localparam int         BIT_PWR_ON   = 3;
  localparam int         CHAN_W       = 3;
  localparam int         NUM_PINS     = 6;
  localparam int         RES_W        = 10;
  localparam int         CONV_BITS    = 16;

  localparam logic [7:0] PIN_EN_RST   = 8'h00;
  localparam logic [7:0] PIN_EN_MASK  = 8'h3F;
  localparam logic [1:0] DIV_RST      = 2'h0;
  localparam logic [2:0] CHAN_MAX     = 3'h5;

  localparam logic [1:0] DIV_4        = 2'h0;
  localparam logic [1:0] DIV_1        = 2'h1;
  localparam logic [1:0] DIV_16       = 2'h2;
  localparam logic [1:0] DIV_2        = 2'h3;

  localparam int         CLK_MHZ      = 200;
  localparam int         OSC_DIV      = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_e;

  typedef struct packed {
    logic                reference_select;
    logic [1:0]          clk_div_sel;
    logic                conv_go;
    logic                conv_power_on;
    logic [CHAN_W-1:0]   chan_sel;
  } ctrl_s;

endpackage

// >>> verilog/adc_sar_core.sv
// Successive-approximation sequencer: one result bit per bit-period tick from the third, RES_W ticks in all.
// Assumes an external comparator answer valid when a bit tick arrives.
`timescale 1ns/1ps
module adc_sar_core #(
  parameter int RES_W     = 10,
  parameter int CONV_BITS = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             start_i,
  input  wire logic             bit_tick_i,
  input  wire logic             cmp_hi_i,
  output logic [RES_W-1:0]      trial_o,
  output logic [RES_W-1:0]      result_o,
  output logic                  done_o,
  output logic                  busy_o
);
  logic [4:0]       cnt_q;
  logic [RES_W-1:0] mask_q;

  // The first bits of each frame are the sample and the last ones settle,
  // so only RES_W of the CONV_BITS periods make decisions.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q    <= 5'h00;
      mask_q   <= '0;
      trial_o  <= '0;
      result_o <= '0;
      done_o   <= 1'b0;
      busy_o   <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy_o)
      begin
        busy_o  <= 1'b1;
        cnt_q   <= 5'h00;
        mask_q  <= {1'b1, {(RES_W-1){1'b0}}};
        trial_o <= {1'b1, {(RES_W-1){1'b0}}};
      end
      else if (busy_o && bit_tick_i)
      begin
        cnt_q <= cnt_q + 5'h01;
        if (mask_q != '0 && cnt_q >= 5'h02)
        begin
          if (!cmp_hi_i)
            trial_o <= (trial_o & ~mask_q) | (mask_q >> 1);
          else
            trial_o <= trial_o | (mask_q >> 1);
          mask_q <= mask_q >> 1;
        end
        if (cnt_q == 5'(CONV_BITS - 1))
        begin
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          result_o <= trial_o;
        end
      end
    end
  end
endmodule

// >>> verilog/sar_adc_control.sv
// Converter control: register port, prescaler, sequencing, sleep handling.
// Assumes a core register port in the clock domain and an external
// comparator whose answer is synchronised here.
// Overview of operation
// - Convert selected input by successive approximation into a 10-bit result.
// - Six pin enable bits make each pin analog when 1.
// - Upper two pin enable bits always read zero.
// - Control bit 7 selects supply or shared pin as reference.
// - Prescaler code 00 by 4, 01 by 1, 10 by 16, 11 by 2.
// - Each result bit takes one bit period; a conversion lasts 16.
// - Writing 1 to run bit starts; writing 0 ignored; hardware clears.
// - Power bit 0 turns reference off; 1 keeps converter operating.
// - Channel codes 0 to 5 route inputs; 6 and 7 select none.
// - Channel changes only while done flag and run bit are low.
// - Completion loads results, clears run bit and sets done flag.
// - Converter keeps running in sleep from the oscillator.
// - End in sleep wakes core if enabled, else shuts converter off.
// - Done flag sets regardless of interrupt mask or global enable.
`timescale 1ns/1ps
module sar_adc_control
  import adc_ctrl_pkg::*;
#(
  parameter int CLK_PER_OSC = adc_ctrl_pkg::OSC_DIV
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [3:0]                  reg_addr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  output logic [7:0]                       reg_rdata_o,
  input  wire logic                        conv_done_clr_i,
  input  wire logic                        conv_wake_en_i,
  input  wire logic                        sleep_i,
  input  wire logic                        cmp_hi_i,
  output logic [adc_ctrl_pkg::NUM_PINS-1:0] pin_analog_o,
  output logic [adc_ctrl_pkg::NUM_PINS-1:0] chan_route_o,
  output logic                             ref_from_pin_o,
  output logic                             ref_power_o,
  output logic [adc_ctrl_pkg::RES_W-1:0]   dac_trial_o,
  output logic                             conv_done_flag_o,
  output logic                             wake_o
);
  import adc_ctrl_pkg::*;

  conv_state_e       st_q;
  ctrl_s             ctrl_q;
  logic [7:0]        pin_en_q;
  logic [RES_W-1:0]  res_q;
  logic              done_q;
  logic              shut_q;
  logic [1:0]        cmp_sync_q;
  logic [7:0]        osc_cnt_q;
  logic              osc_tick;
  logic [4:0]        bit_cnt_q;
  logic [4:0]        bit_div;
  logic              bit_tick;
  logic              start;
  logic              core_done;
  logic              core_busy;
  logic [RES_W-1:0]  core_res;
  logic [RES_W-1:0]  trial;
  logic              wr_ctrl;

  // Bounds of a divide-by-1 conversion: the first oscillator tick after
  // start may fall anywhere within one oscillator period.
  localparam int FAST_MIN = (CONV_BITS - 1) * CLK_PER_OSC + 2;
  localparam int FAST_MAX = CONV_BITS * CLK_PER_OSC + 1;

  assign wr_ctrl = reg_wr_i && reg_addr_i == OFF_CTRL;
  assign start   = st_q == ST_IDLE && ctrl_q.conv_go && !shut_q;

  // Comparator is asynchronous to the clock; second stage alone is read.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cmp_sync_q <= 2'b00;
    else
      cmp_sync_q <= {cmp_sync_q[0], cmp_hi_i};
  end

  // Oscillator tick derived from the system clock.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      osc_cnt_q <= 8'h00;
    else if (osc_cnt_q == 8'(CLK_PER_OSC - 1))
      osc_cnt_q <= 8'h00;
    else
      osc_cnt_q <= osc_cnt_q + 8'h01;
  end
  assign osc_tick = osc_cnt_q == 8'(CLK_PER_OSC - 1);

  always_comb
  begin
    case (ctrl_q.clk_div_sel)
      DIV_4:   bit_div = 5'd3;
      DIV_1:   bit_div = 5'd0;
      DIV_16:  bit_div = 5'd15;
      DIV_2:   bit_div = 5'd1;
      default: bit_div = 5'd3;
    endcase
  end

  // Oscillator keeps ticking in sleep, so conversion continues.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bit_cnt_q <= 5'h00;
    else if (start || st_q != ST_CONV)
      bit_cnt_q <= 5'h00;
    else if (osc_tick)
      bit_cnt_q <= (bit_cnt_q >= bit_div) ? 5'h00 : bit_cnt_q + 5'h01;
  end
  assign bit_tick = osc_tick && bit_cnt_q >= bit_div;

  adc_sar_core #(
    .RES_W     (RES_W),
    .CONV_BITS (CONV_BITS)
  ) u_core (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (start),
    .bit_tick_i (bit_tick),
    .cmp_hi_i   (cmp_sync_q[1]),
    .trial_o    (trial),
    .result_o   (core_res),
    .done_o     (core_done),
    .busy_o     (core_busy)
  );

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      st_q <= ST_IDLE;
    else
      case (st_q)
        ST_IDLE: if (start) st_q <= ST_CONV;
        ST_CONV: if (core_done) st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q   <= '0;
      pin_en_q <= PIN_EN_RST;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == OFF_PIN_EN)
        pin_en_q <= reg_wdata_i & PIN_EN_MASK;
      if (wr_ctrl)
      begin
        ctrl_q.reference_select <= reg_wdata_i[BIT_REF_SEL];
        ctrl_q.clk_div_sel <= reg_wdata_i[BIT_DIV_HI:BIT_DIV_LO];
        ctrl_q.conv_power_on <= reg_wdata_i[BIT_PWR_ON];
        if (!done_q && !ctrl_q.conv_go)
          ctrl_q.chan_sel <= reg_wdata_i[CHAN_W-1:0];
      end
      // Completion clears run; a set in that same cycle is dropped.
      if (core_done)
        ctrl_q.conv_go <= 1'b0;
      else if (wr_ctrl && reg_wdata_i[BIT_GO])
        ctrl_q.conv_go <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      res_q  <= '0;
      done_q <= 1'b0;
      wake_o <= 1'b0;
      shut_q <= 1'b0;
    end
    else
    begin
      wake_o <= 1'b0;
      if (core_done)
      begin
        res_q <= core_res;
        // Set wins over clear; no mask is consulted.
        done_q <= 1'b1;
        if (sleep_i && conv_wake_en_i)
          wake_o <= 1'b1;
        else if (sleep_i)
          shut_q <= 1'b1;
      end
      else if (conv_done_clr_i)
        done_q <= 1'b0;
      if (!sleep_i)
        shut_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o      <= 8'h00;
      pin_analog_o     <= '0;
      chan_route_o     <= '0;
      ref_from_pin_o   <= 1'b0;
      ref_power_o      <= 1'b0;
      dac_trial_o      <= '0;
      conv_done_flag_o <= 1'b0;
    end
    else
    begin
      if (reg_rd_i)
        case (reg_addr_i)
          OFF_PIN_EN: reg_rdata_o <= pin_en_q;
          OFF_CTRL:   reg_rdata_o <= ctrl_q;
          OFF_RES_HI: reg_rdata_o <= res_q[RES_W-1:2];
          OFF_RES_LO: reg_rdata_o <= {6'h00, res_q[1:0]};
          default:    reg_rdata_o <= 8'h00;
        endcase
      pin_analog_o   <= pin_en_q[NUM_PINS-1:0];
      ref_from_pin_o <= ctrl_q.reference_select;
      ref_power_o    <= ctrl_q.conv_power_on && !shut_q;
      dac_trial_o    <= trial;
      conv_done_flag_o <= done_q;
      for (int i = 0; i < NUM_PINS; i++)
        chan_route_o[i] <= ctrl_q.chan_sel == 3'(i);
    end
  end

  AST_GO_CLEARED: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    core_done |=> !ctrl_q.conv_go && done_q)
    else $error("run bit not cleared at completion");
  AST_DONE_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    core_done |=> done_q ##1 conv_done_flag_o)
    else $error("done flag missing");
  AST_CHAN_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (done_q || ctrl_q.conv_go) |=> $stable(ctrl_q.chan_sel))
    else $error("channel changed while locked");
  AST_ZERO_WR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (ctrl_q.conv_go && !core_done) |=> ctrl_q.conv_go)
    else $error("run bit dropped early");
  AST_PIN_HI0: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    pin_en_q[7:6] == 2'b00)
    else $error("unused pin bits set");
  AST_SLEEP_WAKE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (core_done && sleep_i && conv_wake_en_i) |=> wake_o)
    else $error("no wake at end of sleep conversion");
  AST_SHUT: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (core_done && sleep_i && !conv_wake_en_i) |=> ##1 !ref_power_o)
    else $error("converter not shut off");
  AST_FAST_CONV: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (start && ctrl_q.clk_div_sel == DIV_1) |-> ##[FAST_MIN:FAST_MAX] core_done)
    else $error("conversion length wrong");
  AST_RES_LOAD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    core_done |=> res_q == $past(core_res))
    else $error("result not loaded");
  AST_BUSY_CONV: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (st_q == ST_CONV && !core_done) |-> core_busy)
    else $error("sequencer idle during conversion");

  COV_START: cover property (@(posedge clk_sys_i) start);
  COV_DONE: cover property (@(posedge clk_sys_i) core_done);
  COV_WAKE: cover property (@(posedge clk_sys_i) wake_o);
endmodule

// >>> tb/pin_mux_model.sv
// Far side of the block: six analog pins, the mux and the comparator.
// Assumes one-hot routing and a registered trial word from the block.
`timescale 1ns/1ps
module pin_mux_model #(
  parameter logic [59:0] LEVELS = 60'h0
) (
  input  wire logic       clk_sys_i,
  input  wire logic [5:0] chan_route_i,
  input  wire logic [5:0] pin_analog_i,
  input  wire logic [9:0] trial_i,
  output logic            cmp_hi_o
);
  logic       float_q = 1'b0;
  logic [9:0] lvl;
  logic       hit;

  // An open input gives no stable answer, so it toggles every cycle.
  always_ff @(posedge clk_sys_i)
    float_q <= ~float_q;

  always_comb
  begin
    lvl = 10'h000;
    hit = 1'b0;
    for (int i = 0; i < 6; i++)
      if (chan_route_i[i] && pin_analog_i[i])
      begin
        lvl = LEVELS[i*10 +: 10];
        hit = 1'b1;
      end
  end

  // Levels sit half a step above their code, so above means trial <= lvl.
  assign cmp_hi_o = hit ? (trial_i <= lvl) : float_q;
endmodule

// >>> tb/sar_adc_control_bench.sv
// Self-checking bench for the converter control block.
// Assumes the pin model answers the comparator from the routed pin level.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); \
    end \
  end
module sar_adc_control_bench;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic       ref_sel;
    logic [1:0] div;
    logic [2:0] chan;
  } row_s;
  // The comparator answer needs four clocks to return through the
  // registered trial word and the synchroniser, so a bit period must not
  // be shorter than that; the design's default oscillator ratio keeps it.
  localparam int          OSC = 4;
  localparam logic [59:0] LVL = {10'h1FF, 10'h200, 10'h2AA,
                                 10'h155, 10'h000, 10'h3FF};
  logic       clk_sys_i   = 1'b0;
  logic       sys_rst_i   = 1'b1;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [3:0] reg_addr_i  = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       done_clr    = 1'b0;
  logic       wake_en     = 1'b0;
  logic       sleep       = 1'b0;
  logic       cmp_hi;
  logic [7:0] rdata;
  logic [5:0] pin_an;
  logic [5:0] route;
  logic       ref_pin;
  logic       ref_pwr;
  logic       flag;
  logic       wake;
  logic [9:0] trial;
  logic [7:0] oh;
  logic [7:0] cv;
  logic [9:0] lv;
  row_s       r;
  int         err_count  = 0;
  int         n_compared = 0;
  int         cyc        = 0;
  int         wake_n     = 0;
  int         n;
  int         p;
  row_s       rows [6] = '{'{1'h0, 2'h0, 3'h0}, '{1'h1, 2'h1, 3'h1},
                           '{1'h0, 2'h2, 3'h2}, '{1'h1, 2'h3, 3'h3},
                           '{1'h0, 2'h0, 3'h4}, '{1'h1, 2'h1, 3'h5}};

  sar_adc_control #(.CLK_PER_OSC(OSC)) u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
    .conv_done_clr_i(done_clr), .conv_wake_en_i(wake_en),
    .sleep_i(sleep), .cmp_hi_i(cmp_hi), .pin_analog_o(pin_an),
    .chan_route_o(route), .ref_from_pin_o(ref_pin),
    .ref_power_o(ref_pwr), .dac_trial_o(trial),
    .conv_done_flag_o(flag), .wake_o(wake));

  pin_mux_model #(.LEVELS(LVL)) u_pins (
    .clk_sys_i(clk_sys_i), .chan_route_i(route), .pin_analog_i(pin_an),
    .trial_i(trial), .cmp_hi_o(cmp_hi));

  initial
    forever #2.5 clk_sys_i = ~clk_sys_i;

  task automatic close_out();
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (wake === 1'b1)
      wake_n++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  function automatic int per(input logic [1:0] d);
    case (d)
      2'h0: return 4 * OSC;
      2'h1: return OSC;
      2'h2: return 16 * OSC;
      default: return 2 * OSC;
    endcase
  endfunction

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // The flag is looked at after each edge has settled, with a bound.
  task automatic wait_done();
    n = 0;
    while (flag !== 1'b1 && n < 2000)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic clr();
    @(posedge clk_sys_i);
    done_clr <= 1'b1;
    @(posedge clk_sys_i);
    done_clr <= 1'b0;
    tick(2);
    `CHK(flag, 1'b0)
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(OFF_CTRL, 8'h00);
    rd(OFF_PIN_EN, 8'h00);
    rd(4'h3, 8'h00);
    foreach (rows[k])
    begin
      r  = rows[k];
      oh = 8'h01 << r.chan;
      p  = 16 * per(r.div);
      wr(OFF_PIN_EN, 8'hC0 | oh);
      rd(OFF_PIN_EN, oh);
      `CHK(pin_an, oh[5:0])
      cv = {r.ref_sel, r.div, 2'b01, r.chan};
      wr(OFF_CTRL, cv);
      tick(400);
      wr(OFF_CTRL, cv | 8'h10);
      wait_done();
      `CHK(n >= p && n <= p + 8, 1'b1)
      `CHK(route, oh[5:0])
      `CHK(ref_pin, r.ref_sel)
      `CHK(ref_pwr, 1'b1)
      rd(OFF_CTRL, cv);
      lv = LVL[r.chan*10 +: 10];
      rd(OFF_RES_HI, lv[9:2]);
      rd(OFF_RES_LO, {6'h00, lv[1:0]});
      clr();
    end
    `CHK(wake_n, 0)
    wr(OFF_PIN_EN, 8'h3F);
    wr(OFF_CTRL, 8'h09);
    tick(400);
    wr(OFF_CTRL, 8'h19);
    wr(OFF_CTRL, 8'h1B);
    wr(OFF_CTRL, 8'h0B);
    rd(OFF_CTRL, 8'h19);
    wait_done();
    wr(OFF_CTRL, 8'h0C);
    rd(OFF_CTRL, 8'h09);
    clr();
    wr(OFF_CTRL, 8'h07);
    tick(2);
    `CHK(route, 6'h00)
    `CHK(ref_pwr, 1'b0)
    wr(OFF_CTRL, 8'h0E);
    tick(2);
    `CHK(route, 6'h00)
    wr(OFF_CTRL, 8'h0D);
    tick(400);
    @(posedge clk_sys_i);
    sleep   <= 1'b1;
    wake_en <= 1'b1;
    wr(OFF_CTRL, 8'h1D);
    wait_done();
    tick(2);
    `CHK(wake_n, 1)
    rd(OFF_RES_HI, 8'h7F);
    clr();
    tick(2 * per(2'h0));
    @(posedge clk_sys_i);
    wake_en <= 1'b0;
    wr(OFF_CTRL, 8'h1D);
    wait_done();
    tick(2);
    `CHK(flag, 1'b1)
    `CHK(wake_n, 1)
    `CHK(ref_pwr, 1'b0)
    @(posedge clk_sys_i);
    sleep <= 1'b0;
    tick(3);
    `CHK(ref_pwr, 1'b1)
    wr(OFF_CTRL, 8'h19);
    rd(OFF_CTRL, 8'h1D);
    tick(20);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    tick(3);
    `CHK(flag, 1'b0)
    `CHK(route, 6'h00)
    `CHK(pin_an, 6'h00)
    `CHK(ref_pwr, 1'b0)
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(OFF_CTRL, 8'h00);
    rd(OFF_PIN_EN, 8'h00);
    rd(OFF_RES_HI, 8'h00);
    tick(2 * per(2'h0));
    `CHK(flag, 1'b0)
    close_out();
  end
endmodule
